// file: dv/cssl_osc_model.sv
/*
  Far-side oscillator model: a counted burst of one-cycle ticks.
  Assumes ticks are synchronous to the bench clock.
*/
`default_nettype none

module cssl_osc_model (
  // Control
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [16:0] num_i,
  input  wire logic [3:0]  gap_i,
  // Oscillator side
  output logic             tick_o,
  output logic             busy_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [16:0] left_q = 17'h0;
  logic [3:0]  wait_q = 4'h0;
  logic        tick_q = 1'b0;

  // Fixed spacing, so the period never jumps between cycles
  always @(posedge clk_i) begin
    tick_q <= 1'b0;
    if (go_i) begin
      left_q <= num_i;
      wait_q <= gap_i;
    end else if (left_q != 17'h0) begin
      if (wait_q == 4'h0) begin
        tick_q <= 1'b1;
        left_q <= left_q - 17'h1;
        wait_q <= gap_i;
      end else begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end

  // Tick out; busy from request to last tick
  assign tick_o = tick_q;
  assign busy_o = go_i | (left_q != 17'h0);
endmodule : cssl_osc_model

`default_nettype wire

// file: dv/cssl_top_asserts.sv
/*
  Checker for cssl_top: source class, tick copies, gating, trim load.
  Assumes it is bound to cssl_top and sees only its ports.
*/
`default_nettype none

module cssl_top_asserts (
  // Clock, reset, fuses
  input wire logic       CLK_I,
  input wire logic       RESETN_I,
  input wire logic [3:0] CLOCK_SOURCE_FUSES_I,
  input wire logic [1:0] STARTUP_TIME_FUSES_I,
  input wire logic [7:0] CALIBRATION_BYTE_I,
  // Ticks in
  input wire logic       WDT_OSC_TICK_I,
  input wire logic       LFX_TICK_I,
  input wire logic       ERC_TICK_I,
  input wire logic       IRC_TICK_I,
  input wire logic       EXT_CLK_TICK_I,
  // Outputs
  input wire logic       CPU_CLK_EN_O,
  input wire logic       NVM_TICK_O,
  input wire logic       WDT_TICK_O,
  input wire logic [2:0] SOURCE_CLASS_O,
  input wire logic [7:0] OSCILLATOR_TRIM_O
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] src;
  logic [1:0] up_q;
  logic       sel_tick;

  // Fuse field and tick of the chosen source
  assign src = CLOCK_SOURCE_FUSES_I;
  assign sel_tick = src == 4'h9 ? LFX_TICK_I : src >= 4'h5 ? ERC_TICK_I :
                    src != 4'h0 ? IRC_TICK_I : EXT_CLK_TICK_I;

  // Cycles since release, so the reset tail is skipped
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end

  // ------
  // Properties
  // ------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_up;
    $rose(RESETN_I);
  endsequence
  sequence s_quiet;
    !CPU_CLK_EN_O [*8];
  endsequence

  property p_lfx; src == 4'h9 |-> SOURCE_CLASS_O == 3'h3; endproperty
  property p_erc; src inside {[4'h5:4'h8]} |-> SOURCE_CLASS_O == 3'h2; endproperty
  property p_irc; src inside {[4'h1:4'h4]} |-> SOURCE_CLASS_O == 3'h1; endproperty
  property p_ext; src == 4'h0 |-> SOURCE_CLASS_O == 3'h0; endproperty
  property p_wdt; up_q == 2'h3 && WDT_OSC_TICK_I |=> WDT_TICK_O; endproperty
  property p_nvm; up_q == 2'h3 && IRC_TICK_I |=> NVM_TICK_O; endproperty
  property p_gate; CPU_CLK_EN_O |-> $past(sel_tick); endproperty
  property p_trim; s_up |-> ##[3:4] OSCILLATOR_TRIM_O == CALIBRATION_BYTE_I; endproperty
  property p_quiet; s_up |-> s_quiet; endproperty
  property p_fault;
    (src == 4'h9 || src <= 4'h4) && STARTUP_TIME_FUSES_I == 2'h3 |-> !CPU_CLK_EN_O;
  endproperty

  a_lfx: assert property (p_lfx) else $error("class wrong for crystal");
  a_erc: assert property (p_erc) else $error("class wrong for ext RC");
  a_irc: assert property (p_irc) else $error("class wrong for int RC");
  a_ext: assert property (p_ext) else $error("class wrong for ext clock");
  a_wdt: assert property (p_wdt) else $error("watchdog tick lost");
  a_nvm: assert property (p_nvm) else $error("memory tick lost");
  a_gate: assert property (p_gate) else $error("enable without tick");
  a_trim: assert property (p_trim) else $error("trim not loaded");
  a_quiet: assert property (p_quiet) else $error("enable too soon");
  a_fault: assert property (p_fault) else $error("enable on reserved code");
endmodule : cssl_top_asserts

bind cssl_top cssl_top_asserts u_asserts (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .CLOCK_SOURCE_FUSES_I(CLOCK_SOURCE_FUSES_I),
  .STARTUP_TIME_FUSES_I(STARTUP_TIME_FUSES_I), .CALIBRATION_BYTE_I(CALIBRATION_BYTE_I),
  .WDT_OSC_TICK_I(WDT_OSC_TICK_I), .LFX_TICK_I(LFX_TICK_I), .ERC_TICK_I(ERC_TICK_I),
  .IRC_TICK_I(IRC_TICK_I), .EXT_CLK_TICK_I(EXT_CLK_TICK_I), .CPU_CLK_EN_O(CPU_CLK_EN_O),
  .NVM_TICK_O(NVM_TICK_O), .WDT_TICK_O(WDT_TICK_O), .SOURCE_CLASS_O(SOURCE_CLASS_O),
  .OSCILLATOR_TRIM_O(OSCILLATOR_TRIM_O)
);

`default_nettype wire

// file: dv/cssl_top_tb.sv
/*
  Self-checking bench for cssl_top: start-up counts per fuse setting,
  trim load and access, sleep and wake.
  Assumes cssl_osc_model supplies watchdog and source ticks.
*/
`default_nettype none

module cssl_top_tb
  import cssl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [3:0] s;
    logic [1:0] t;
    logic [2:0] c;
    int         w;
    int         n;
    bit         f;
  } cssl_row_t;

  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        wgo = 1'b0, sgo = 1'b0, dec = 1'b0, wake = 1'b0, slp = 1'b0;
  logic        pready, perr, en, wtk, stk, wbusy, sbusy, er;
  logic [16:0] wnum = 17'h0, snum = 17'h0;
  logic [7:0]  paddr = 8'h0, cal = 8'h0, trim;
  logic [7:0]  tv [3] = '{8'hff, 8'h00, 8'h7f};
  logic [3:0]  src = 4'h1;
  logic [2:0]  cls = 3'h1, scls;
  logic [1:0]  startup_time_fuses = 2'h0;
  logic [31:0] pwd = 32'h0, prd, rd;
  int          err_total = 0, checks_done = 0, ens = 0, e0;
  cssl_row_t   rows [14] = '{
    '{4'h1, 2'h0, 3'h1, 0, 6, 1'b0}, '{4'h2, 2'h2, 3'h1, 65536, 6, 1'b0},
    '{4'h3, 2'h0, 3'h1, 0, 6, 1'b0}, '{4'h4, 2'h1, 3'h1, 4096, 6, 1'b0},
    '{4'h5, 2'h0, 3'h2, 0, 18, 1'b0}, '{4'h6, 2'h0, 3'h2, 0, 18, 1'b0},
    '{4'h7, 2'h1, 3'h2, 4096, 18, 1'b0},
    '{4'h8, 2'h3, 3'h2, 4096, 6, 1'b0}, '{4'h9, 2'h0, 3'h3, 4096, 1024, 1'b0},
    '{4'h0, 2'h0, 3'h0, 0, 6, 1'b0}, '{4'h9, 2'h3, 3'h3, 0, 0, 1'b1},
    '{4'h1, 2'h3, 3'h1, 0, 0, 1'b1}, '{4'h0, 2'h3, 3'h0, 0, 0, 1'b1},
    '{4'ha, 2'h0, 3'h4, 0, 0, 1'b1}};

  // ------
  // Partner oscillators and design
  // ------
  cssl_osc_model u_wdt (.clk_i(clk), .go_i(wgo), .num_i(wnum), .gap_i(4'h0), .tick_o(wtk),
                        .busy_o(wbusy));
  cssl_osc_model u_src (.clk_i(clk), .go_i(sgo), .num_i(snum), .gap_i(4'h2), .tick_o(stk),
                        .busy_o(sbusy));
  cssl_top uut (
    .CLK_I(clk), .RESETN_I(rstn), .CLOCK_SOURCE_FUSES_I(src), .STARTUP_TIME_FUSES_I(startup_time_fuses),
    .CALIBRATION_BYTE_I(cal), .WDT_OSC_TICK_I(wtk),
    .LFX_TICK_I(cls == 3'h3 ? stk : dec), .ERC_TICK_I(cls == 3'h2 ? stk : dec),
    .IRC_TICK_I(cls == 3'h1 ? stk : dec), .EXT_CLK_TICK_I(cls == 3'h0 ? stk : dec),
    .WAKE_I(wake), .SLEEP_I(slp), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
    .CPU_CLK_EN_O(en), .NVM_TICK_O(), .WDT_TICK_O(), .SOURCE_CLASS_O(scls),
    .OSCILLATOR_TRIM_O(trim));

  // 25 MHz clock
  always #20 clk = ~clk;

  // Decoy ticks on unselected sources; count clock enables
  always @(posedge clk) begin
    dec <= ~dec;
    if (en === 1'b1) ens <= ens + 1;
  end

  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // APB transfer; result left in rd and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic pulse(input logic wd, input int n);
    @(posedge clk);
    wgo <= wd;
    sgo <= !wd;
    wnum <= 17'(n);
    snum <= 17'(n);
    @(posedge clk);
    wgo <= 1'b0;
    sgo <= 1'b0;
    while (wbusy || sbusy) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask : pulse

  task automatic run_src(input int n, input int x, input string m);
    @(negedge clk);
    e0 = ens;
    pulse(1'b0, n);
    @(negedge clk);
    chk(ens - e0 == x, m);
  endtask : run_src

  task automatic boot(input cssl_row_t r, input logic [7:0] c);
    @(posedge clk);
    rstn <= 1'b0;
    src <= r.s;
    startup_time_fuses <= r.t;
    cls <= r.c;
    cal <= c;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : boot

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    foreach (rows[i]) begin
      boot(rows[i], 8'h30 + 8'(i));
      apb(1'b0, CSSL_OFS_TRIM, 32'h0);
      chk(rd === {24'h0, 8'h30 + 8'(i)} && trim === rd[7:0], "trim load");
      chk(scls === rows[i].c, "class");
      if (rows[i].w > 0) begin
        pulse(1'b1, rows[i].w - 1);
        run_src(rows[i].n + 2, 0, "early enable");
        pulse(1'b1, 1);
      end
      run_src(rows[i].n + 4, rows[i].f ? 0 : 4, "start-up");
      apb(1'b0, CSSL_OFS_STATUS, 32'h0);
      chk(rd[9:4] === {rows[i].t, rows[i].s} && rd[1:0] === {rows[i].f, !rows[i].f}, "status");
      $display("row %0d done", i);
    end
    boot(rows[0], 8'h5a);
    run_src(7, 1, "run");
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    run_src(5, 0, "asleep");
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    run_src(9, 3, "wake");
    @(posedge clk);
    slp <= 1'b1;
    wake <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    wake <= 1'b0;
    run_src(9, 3, "wake with sleep");
    $display("sleep test done");
    foreach (tv[j]) begin
      apb(1'b1, CSSL_OFS_TRIM, {24'h1, tv[j]}); // no memory write in flight
      apb(1'b0, CSSL_OFS_TRIM, 32'h0);
      chk(rd === {24'h0, tv[j]} && trim === tv[j] && er === 1'b0, "trim rw");
    end
    apb(1'b1, 8'h0c, 32'h55);
    apb(1'b0, 8'h0c, 32'h0);
    chk(er === 1'b1 && rd === 32'h0 && trim === 8'h7f, "unmapped");
    $display("register test done");
    give_verdict();
  end

  // Cut a hang short; the tests need about 90k cycles, this is 97.5k
  initial begin
    #3900000;
    err_total++;
    $display("CHECK FAILED at %0t: timeout", $time);
    give_verdict();
  end
endmodule : cssl_top_tb

`default_nettype wire

// file: rtl/cssl_counter.sv
/*
  Enabled down counter used for both start-up waits. Counts on a
  one-cycle enable pulse; reports done when the count reaches zero.
*/
`default_nettype none

module cssl_counter #(
  parameter int W = 17
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  input  wire logic         tick_i,
  // Status
  output logic              done_o
);

  logic [W-1:0] cnt_q;

  // Load or count down on each tick
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= value_i;
    end else if (tick_i && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign done_o = (cnt_q == '0) && !load_i;

endmodule : cssl_counter

`default_nettype wire

// file: rtl/cssl_decode.sv
/*
  Fuse decoder: turns the clock source and start-up time fuse fields
  into a start-up plan. Assumes fuses are static while in use.
*/
`default_nettype none

module cssl_decode
  import cssl_pkg::*;
(
  // Fuse fields
  input  wire logic [3:0] src_i,
  input  wire logic [1:0] sut_i,
  // Decoded plan
  output cssl_plan_t      plan_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Reset delay picked by start-up code for 6/18 CK sources
  function automatic logic [CSSL_RD_W-1:0] rd3(input logic [1:0] s);
    logic [CSSL_RD_W-1:0] r;
    r = '0;
    if (s == 2'h1) begin
      r = CSSL_RD_W'(CSSL_WDT_4K);
    end else if (s == 2'h2) begin
      r = CSSL_RD_W'(CSSL_WDT_64K);
    end
    return r;
  endfunction : rd3

  // Table lookup per source class
  always_comb begin
    plan_o            = '0;
    plan_o.cls        = CSSL_CLS_NONE;
    if (src_i == CSSL_SRC_LF_XTAL) begin
      plan_o.cls        = CSSL_CLS_LFX;
      plan_o.valid      = (sut_i != 2'h3);
      plan_o.ck_cycles  = CSSL_SU_W'((sut_i == 2'h2) ? CSSL_CK_32K : CSSL_CK_1K);
      plan_o.wdt_cycles = (sut_i == 2'h0) ? CSSL_RD_W'(CSSL_WDT_4K)
                                          : CSSL_RD_W'(CSSL_WDT_64K);
    end else if (src_i >= CSSL_SRC_ERC_FIRST && src_i <= CSSL_SRC_ERC_LAST) begin
      plan_o.cls        = CSSL_CLS_ERC;
      plan_o.valid      = 1'b1;
      if (sut_i == 2'h3) begin
        plan_o.ck_cycles  = CSSL_SU_W'(CSSL_CK_6);
        plan_o.wdt_cycles = CSSL_RD_W'(CSSL_WDT_4K);
      end else begin
        plan_o.ck_cycles  = CSSL_SU_W'(CSSL_CK_18);
        plan_o.wdt_cycles = rd3(sut_i);
      end
    end else if (src_i >= CSSL_SRC_IRC_FIRST && src_i <= CSSL_SRC_IRC_LAST) begin
      plan_o.cls        = CSSL_CLS_IRC;
      plan_o.valid      = (sut_i != 2'h3);
      plan_o.ck_cycles  = CSSL_SU_W'(CSSL_CK_6);
      plan_o.wdt_cycles = rd3(sut_i);
    end else if (src_i == CSSL_SRC_EXT_CLK) begin
      plan_o.cls        = CSSL_CLS_EXT;
      plan_o.valid      = (sut_i != 2'h3);
      plan_o.ck_cycles  = CSSL_SU_W'(CSSL_CK_6);
      plan_o.wdt_cycles = rd3(sut_i);
    end
  end

endmodule : cssl_decode

`default_nettype wire

// file: rtl/cssl_pkg.sv
/*
  Package for the clock source and start-up select block: fuse codes,
  start-up cycle counts, reset delay counts, register map and carriers.
  Assumes a single 25 MHz system clock and an APB register bus.
*/
`default_nettype none

package cssl_pkg;

  // ----------------------------------------------------------------
  // Clock source fuse codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CSSL_SRC_EXT_CLK    = 4'h0;
  localparam logic [3:0] CSSL_SRC_IRC_FIRST  = 4'h1;
  localparam logic [3:0] CSSL_SRC_IRC_LAST   = 4'h4;
  localparam logic [3:0] CSSL_SRC_ERC_FIRST  = 4'h5;
  localparam logic [3:0] CSSL_SRC_ERC_LAST   = 4'h8;
  localparam logic [3:0] CSSL_SRC_LF_XTAL    = 4'h9;
  localparam logic [3:0] CSSL_SRC_DEFAULT    = 4'h1;
  localparam logic [1:0] CSSL_SUT_DEFAULT    = 2'h2;

  // ----------------------------------------------------------------
  // Start-up counts in selected-clock cycles
  // ----------------------------------------------------------------
  localparam int unsigned CSSL_CK_6   = 6;
  localparam int unsigned CSSL_CK_18  = 18;
  localparam int unsigned CSSL_CK_1K  = 1024;
  localparam int unsigned CSSL_CK_32K = 32768;
  localparam int          CSSL_SU_W   = 16;

  // ----------------------------------------------------------------
  // Reset delays in watchdog oscillator cycles
  // ----------------------------------------------------------------
  localparam int unsigned CSSL_WDT_4K  = 4096;
  localparam int unsigned CSSL_WDT_64K = 65536;
  localparam int          CSSL_RD_W    = 17;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CSSL_OFS_TRIM   = 8'h00;
  localparam logic [7:0] CSSL_OFS_STATUS = 8'h04;
  localparam logic [7:0] CSSL_OFS_WAKE   = 8'h08;
  localparam int         CSSL_ST_READY   = 0;
  localparam int         CSSL_ST_FAULT   = 1;
  localparam int         CSSL_ST_SRC_LSB = 4;
  localparam int         CSSL_ST_SUT_LSB = 8;
  localparam logic [7:0] CSSL_TRIM_MAX   = 8'hff;

  // Source class carried to the rest of the chip
  typedef enum logic [2:0] {
    CSSL_CLS_EXT  = 3'b000,
    CSSL_CLS_IRC  = 3'b001,
    CSSL_CLS_ERC  = 3'b010,
    CSSL_CLS_LFX  = 3'b011,
    CSSL_CLS_NONE = 3'b100
  } cssl_class_t;

  // Decoded start-up plan
  typedef struct packed {
    cssl_class_t             cls;
    logic                    valid;
    logic [CSSL_SU_W-1:0]    ck_cycles;
    logic [CSSL_RD_W-1:0]    wdt_cycles;
  } cssl_plan_t;

endpackage : cssl_pkg

`default_nettype wire

// file: rtl/cssl_top.sv
/*
  Clock source and start-up select: decodes the clock fuses, times
  reset delay on the watchdog oscillator tick and start-up on the
  selected source tick, gates the processor clock enable, and holds
  the oscillator trim register on APB.
  Assumes oscillator edges arrive as one-cycle enable pulses already
  synchronous to CLK_I, and fuse inputs are static.
*/
`default_nettype none

module cssl_top
  import cssl_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  // Fuses and factory calibration
  input  wire logic [3:0]  CLOCK_SOURCE_FUSES_I,
  input  wire logic [1:0]  STARTUP_TIME_FUSES_I,
  input  wire logic [7:0]  CALIBRATION_BYTE_I,
  // Oscillator tick pulses
  input  wire logic        WDT_OSC_TICK_I,
  input  wire logic        LFX_TICK_I,
  input  wire logic        ERC_TICK_I,
  input  wire logic        IRC_TICK_I,
  input  wire logic        EXT_CLK_TICK_I,
  // Sleep controller
  input  wire logic        WAKE_I,
  input  wire logic        SLEEP_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Clock outputs
  output logic             CPU_CLK_EN_O,
  output logic             NVM_TICK_O,
  output logic             WDT_TICK_O,
  output logic [2:0]       SOURCE_CLASS_O,
  output logic [7:0]       OSCILLATOR_TRIM_O
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic       rst_s1_q;
  logic       rst_n;

  // Two-stage release of the asynchronous reset
  // Assertion stays asynchronous so the sequencer drops out at once;
  // release is synchronous so no flop sees it inside its setup window
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Fuse decode
  // ----------------------------------------------------------------
  cssl_plan_t plan;

  // Purely combinational decoder; its plan is as static as the fuses
  cssl_decode u_decode (
    .src_i  (CLOCK_SOURCE_FUSES_I),
    .sut_i  (STARTUP_TIME_FUSES_I),
    .plan_o (plan)
  );

  // Tick of the selected source
  // Unused and reserved source codes give no tick at all
  logic src_tick;
  always_comb begin
    case (plan.cls)
      CSSL_CLS_LFX: src_tick = LFX_TICK_I;
      CSSL_CLS_ERC: src_tick = ERC_TICK_I;
      CSSL_CLS_IRC: src_tick = IRC_TICK_I;
      CSSL_CLS_EXT: src_tick = EXT_CLK_TICK_I;
      default:      src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  // RESET: first edge after release, fuse setting checked
  // RDLY:  reset delay counted on the watchdog oscillator
  // SU:    start-up wait counted on the selected source
  // RUN:   processor clock enable follows the source ticks
  // SLEEP: power-down or power-save, no enable until a wake
  // FAULT: reserved fuse setting, held until the next reset
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_RDLY  = 3'b001,
    ST_SU    = 3'b010,
    ST_RUN   = 3'b011,
    ST_SLEEP = 3'b100,
    ST_FAULT = 3'b101
  } cssl_state_t;

  cssl_state_t state_q;
  cssl_state_t state_d;
  logic        rd_load;
  logic        su_load;
  logic        rd_done;
  logic        su_done;
  logic        wake_pend_q;

  // Reset delay on watchdog ticks
  // A zero load is done at once, so codes without delay skip this wait
  cssl_counter #(.W(CSSL_RD_W)) u_rdly (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .load_i  (rd_load),
    .value_i (plan.wdt_cycles),
    .tick_i  (WDT_OSC_TICK_I),
    .done_o  (rd_done)
  );

  // Start-up wait on selected-source ticks
  cssl_counter #(.W(CSSL_SU_W)) u_su (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .load_i  (su_load),
    .value_i (plan.ck_cycles),
    .tick_i  (src_tick),
    .done_o  (su_done)
  );

  // Next state and counter loads
  // Fuses are static, so the plan is read straight from the decoder
  always_comb begin
    state_d = state_q;
    rd_load = 1'b0;
    su_load = 1'b0;
    case (state_q)
      ST_RESET: begin
        if (!plan.valid) begin
          state_d = ST_FAULT;
        end else begin
          rd_load = 1'b1;
          state_d = ST_RDLY;
        end
      end
      ST_RDLY: begin
        if (rd_done) begin
          su_load = 1'b1;
          state_d = ST_SU;
        end
      end
      ST_SU: begin
        if (su_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (SLEEP_I) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (WAKE_I || wake_pend_q) begin
          su_load = 1'b1;
          state_d = ST_SU;
        end
      end
      ST_FAULT: state_d = ST_FAULT;
      default:  state_d = ST_RESET;
    endcase
  end

  // State register
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Wake request caught while entering sleep is kept
  // Without it a wake in the same cycle as the sleep request is lost
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wake_pend_q <= 1'b0;
    end else if (state_q == ST_SLEEP) begin
      wake_pend_q <= 1'b0;
    end else if (state_q == ST_RUN && SLEEP_I && WAKE_I) begin
      wake_pend_q <= 1'b1;
    end
  end

  // Processor clock enable only after both waits
  // Registered, so each enable trails its source tick by one cycle
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CPU_CLK_EN_O <= 1'b0;
    end else begin
      CPU_CLK_EN_O <= (state_d == ST_RUN) && src_tick;
    end
  end

  // Nonvolatile timing from the internal oscillator; watchdog tick from the watchdog oscillator
  // Both copies are one cycle late, like the other registered outputs
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      NVM_TICK_O <= 1'b0;
      WDT_TICK_O <= 1'b0;
    end else begin
      NVM_TICK_O <= IRC_TICK_I;
      WDT_TICK_O <= WDT_OSC_TICK_I;
    end
  end

  assign SOURCE_CLASS_O = plan.cls;

  // ----------------------------------------------------------------
  // Oscillator trim register and APB
  // ----------------------------------------------------------------
  logic [7:0]  trim_q;
  logic        load_cal_q;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rdata_d;

  // Map: trim at 0x00, status at 0x04, sequencer state at 0x08;
  // no wait states, so every access ends at its first access edge
  assign addr_ok = (PADDR_I == CSSL_OFS_TRIM) || (PADDR_I == CSSL_OFS_STATUS)
                   || (PADDR_I == CSSL_OFS_WAKE);
  assign wr_en   = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en   = PSEL_I && PENABLE_I && !PWRITE_I;

  // Calibration loaded on the first edge after every reset
  // A bus write in that same cycle loses to the calibration load
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      load_cal_q <= 1'b1;
      trim_q     <= 8'h00;
    end else if (load_cal_q) begin
      load_cal_q <= 1'b0;
      trim_q     <= CALIBRATION_BYTE_I;
    end else if (wr_en && PADDR_I == CSSL_OFS_TRIM) begin
      trim_q     <= PWDATA_I[7:0];
    end
  end

  // Trim drives the internal RC code directly; higher is faster
  assign OSCILLATOR_TRIM_O = trim_q;

  // Read mux
  // Upper trim bits and unmapped addresses read back as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (PADDR_I)
      CSSL_OFS_TRIM: rdata_d[7:0] = trim_q;
      CSSL_OFS_STATUS: begin
        rdata_d[CSSL_ST_READY]                 = (state_q == ST_RUN);
        rdata_d[CSSL_ST_FAULT]                 = (state_q == ST_FAULT);
        rdata_d[CSSL_ST_SRC_LSB +: 4]          = CLOCK_SOURCE_FUSES_I;
        rdata_d[CSSL_ST_SUT_LSB +: 2]          = STARTUP_TIME_FUSES_I;
      end
      CSSL_OFS_WAKE: rdata_d[2:0] = state_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Registered read data, taken in setup phase
  // Holds steady through the access phase for the master to take
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= rdata_d;
    end
  end

  // Always ready; error only in the access phase, off the map
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = (rd_en || wr_en) && !addr_ok;

endmodule : cssl_top

`default_nettype wire
